// file: inc/lps_pkg.sv
/*
 * Shared constants and types of the light and proximity measurement
 * sequencer: register indices, field positions, reset values, timing.
 * Assumes a 40 MHz system clock; byte address is four times the index.
 */
package lps_pkg;
    localparam int CLK_NS = 25;
    localparam int STEP_NS = 2720000;
    localparam int PULSE_PER_NS = 16000;
    localparam int LED_ON_NS = 7330;
    localparam int STEP_CYC = STEP_NS / CLK_NS;
    localparam int PULSE_PER_CYC = PULSE_PER_NS / CLK_NS;
    localparam int LED_ON_CYC = LED_ON_NS / CLK_NS;

    localparam logic [5:0] IDX_ENABLE = 6'h00;
    localparam logic [5:0] IDX_LIGHT_TIME = 6'h01;
    localparam logic [5:0] IDX_PROX_TIME = 6'h02;
    localparam logic [5:0] IDX_WAIT_TIME = 6'h03;
    localparam logic [5:0] IDX_PULSES = 6'h0E;
    localparam logic [5:0] IDX_CONTROL = 6'h0F;
    localparam logic [5:0] IDX_STATUS = 6'h13;
    localparam logic [5:0] IDX_CLEAR_LO = 6'h14;
    localparam logic [5:0] IDX_CLEAR_HI = 6'h15;
    localparam logic [5:0] IDX_IR_LO = 6'h16;
    localparam logic [5:0] IDX_IR_HI = 6'h17;
    localparam logic [5:0] IDX_PROX_LO = 6'h18;
    localparam logic [5:0] IDX_PROX_HI = 6'h19;

    localparam int BIT_POWER_ON = 0;
    localparam int BIT_LIGHT_EN = 1;
    localparam int BIT_PROX_EN = 2;
    localparam int BIT_WAIT_EN = 3;
    localparam int DRIVE_LSB = 6;

    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_TIME = 8'hFF;
    localparam logic [7:0] RST_PULSES = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [8:0] FULL_STEPS = 9'h100;
    localparam logic [18:0] MAX_COUNT = 19'h0FFFF;

    typedef enum logic [2:0] {SEQ_SLEEP, SEQ_START, SEQ_PROX, SEQ_WAIT, SEQ_LIGHT} lps_state_e;
endpackage : lps_pkg

// file: inc/lps_step_if.sv
/*
 * Carrier between the sequencer and its step timer.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/100ps
interface lps_step_if;
    logic start;
    logic [8:0] steps;
    logic done;
    modport seq (output start, output steps, input done);
    modport tmr (input start, input steps, output done);
endinterface : lps_step_if

// file: hdl/lps_step_timer.sv
/*
 * Step timer: counts a number of fixed-length steps and pulses done.
 * Assumes start is a one-cycle pulse; a new start restarts the count.
 */
`timescale 1ns/100ps
module lps_step_timer #(
    parameter int P_STEP_CYCLES = lps_pkg::STEP_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    lps_step_if.tmr step
);
    localparam int CW = $clog2(P_STEP_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(P_STEP_CYCLES - 1);

    typedef struct packed {
        logic busy;
        logic [CW-1:0] cyc;
        logic [8:0] left;
        logic done;
    } lps_tmr_s;

    lps_tmr_s st;
    lps_tmr_s next_st;

    always_comb
    begin
        next_st = st;
        next_st.done = 1'b0;
        if (step.start)
        begin
            next_st.busy = 1'b1;
            next_st.cyc = '0;
            next_st.left = step.steps;
        end
        else if (st.busy)
        begin
            if (st.cyc == LAST)
            begin
                next_st.cyc = '0;
                if (st.left <= 9'h001)
                begin
                    next_st.busy = 1'b0;
                    next_st.done = 1'b1;
                end
                else
                begin
                    next_st.left = st.left - 9'h001;
                end
            end
            else
            begin
                next_st.cyc = st.cyc + CW'(1);
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign step.done = st.done;
endmodule : lps_step_timer

// file: hdl/lps_sequencer.sv
/*
 * Light and proximity measurement sequencer with Avalon-MM register slave.
 * Assumes converter pulses arrive synchronous to i_sys_clk, one per count.
 */
// How it works
// - After reset the sequencer sleeps and converts nothing until power-on is set.
// - Setting power-on moves the sequencer from sleep to start.
// - Start leads to proximity, wait, then light, repeating in that order.
// - Each function runs only when its own enable bit is set.
// - Clearing power-on lets running conversions finish, then sleep follows.
// - Power-on is bit 0 of register index 0.
// - Proximity conversion time advances in 2.72 ms steps; 0xFF gives one step.
// - Each converter integrates from 1 to 256 steps per its time register.
// - Full scale is 1024 counts per integration step, capped at 65535.
// - Each proximity measurement emits 0 to 255 LED pulses as programmed.
// - Bursts repeat every 16 us with about 7.33 us LED on time.
// - Two-bit drive level selects 100, 50, 25 or 12.5 mA sink current.
// - Wait timer counts 1 to 256 steps of 2.72 ms; 0xFF gives one.
// - Clear and infrared channels each integrate into their own digital count.
// - Time registers hold two's complement counts: steps equal 256 minus value.
// - Results move to data registers at conversion end, read double buffered.
`timescale 1ns/100ps
module lps_sequencer #(
    parameter int P_STEP_CYCLES = lps_pkg::STEP_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] i_avs_writedata,
    input wire logic i_clear_pulse,
    input wire logic i_ir_pulse,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_led_sink_output,
    output logic [1:0] o_led_drive_level
);
    localparam logic [9:0] PER_LAST = 10'(lps_pkg::PULSE_PER_CYC - 1);
    localparam logic [9:0] ON_CYC = 10'(lps_pkg::LED_ON_CYC);

    typedef struct packed {
        lps_pkg::lps_state_e state;
        logic run;
        logic tdone;
        logic [7:0] enable;
        logic [7:0] light_integration_time;
        logic [7:0] prox_conversion_time;
        logic [7:0] wait_time_setting;
        logic [7:0] pulses;
        logic [7:0] control;
        logic [15:0] clear_channel_count;
        logic [15:0] infrared_channel_count;
        logic [15:0] prox_count;
        logic [15:0] acc_clear;
        logic [15:0] acc_ir;
        logic [7:0] shadow;
        logic [7:0] pulses_left;
        logic [9:0] pulse_cyc;
        logic led;
        logic tmr_start;
        logic [8:0] tmr_steps;
        logic ack;
        logic waitreq;
        logic [31:0] rdata;
    } lps_seq_s;

    lps_seq_s st;
    lps_seq_s next_st;
    lps_step_if step ();

    // Two's complement time value to a step count of 1 to 256
    function automatic logic [8:0] to_steps(input logic [7:0] t);
        to_steps = lps_pkg::FULL_STEPS - {1'b0, t};
    endfunction : to_steps

    // Saturating count, never above 1024 per step nor 16 bits
    function automatic logic [15:0] sat_add(input logic [15:0] acc, input logic [8:0] steps);
        logic [18:0] lim;
        lim = {steps, 10'h000};
        if (lim > lps_pkg::MAX_COUNT)
            lim = lps_pkg::MAX_COUNT;
        sat_add = ({3'h0, acc} < lim) ? acc + 16'h0001 : acc;
    endfunction : sat_add

    always_comb
    begin
        next_st = st;
        next_st.tmr_start = 1'b0;
        // A done from an aborted earlier run must not end the run just started
        if (step.done && !st.tmr_start)
            next_st.tdone = 1'b1;
        unique case (st.state)
            lps_pkg::SEQ_SLEEP:
            begin
                if (st.enable[lps_pkg::BIT_POWER_ON])
                    next_st.state = lps_pkg::SEQ_START;
            end
            lps_pkg::SEQ_START:
            begin
                next_st.state = st.enable[lps_pkg::BIT_POWER_ON] ? lps_pkg::SEQ_PROX : lps_pkg::SEQ_SLEEP;
            end
            lps_pkg::SEQ_PROX:
            begin
                if (!st.run)
                begin
                    next_st.state = lps_pkg::SEQ_WAIT;
                end
                else
                begin
                    if (i_ir_pulse)
                        next_st.acc_ir = sat_add(st.acc_ir, to_steps(st.prox_conversion_time));
                    if (st.pulses_left != 8'h00)
                    begin
                        next_st.pulse_cyc = (st.pulse_cyc == PER_LAST) ? 10'h000 : st.pulse_cyc + 10'h001;
                        if (st.pulse_cyc == PER_LAST)
                            next_st.pulses_left = st.pulses_left - 8'h01;
                    end
                    // Burst may outlast the conversion time; leave only after both
                    if (st.tdone && st.pulses_left == 8'h00)
                    begin
                        next_st.prox_count = st.acc_ir;
                        next_st.state = st.enable[lps_pkg::BIT_POWER_ON] ? lps_pkg::SEQ_WAIT : lps_pkg::SEQ_SLEEP;
                    end
                end
            end
            lps_pkg::SEQ_WAIT:
            begin
                if (!st.enable[lps_pkg::BIT_POWER_ON])
                    next_st.state = lps_pkg::SEQ_SLEEP;
                else if (!st.run || st.tdone)
                    next_st.state = lps_pkg::SEQ_LIGHT;
            end
            lps_pkg::SEQ_LIGHT:
            begin
                if (!st.run)
                begin
                    next_st.state = st.enable[lps_pkg::BIT_POWER_ON] ? lps_pkg::SEQ_START : lps_pkg::SEQ_SLEEP;
                end
                else
                begin
                    if (i_clear_pulse)
                        next_st.acc_clear = sat_add(st.acc_clear, to_steps(st.light_integration_time));
                    if (i_ir_pulse)
                        next_st.acc_ir = sat_add(st.acc_ir, to_steps(st.light_integration_time));
                    if (st.tdone)
                    begin
                        next_st.clear_channel_count = st.acc_clear;
                        next_st.infrared_channel_count = st.acc_ir;
                        next_st.state = st.enable[lps_pkg::BIT_POWER_ON] ? lps_pkg::SEQ_START : lps_pkg::SEQ_SLEEP;
                    end
                end
            end
        endcase

        // Entry into a measuring state arms its timer and clears its sums
        if (next_st.state != st.state)
        begin
            next_st.tdone = 1'b0;
            next_st.acc_clear = 16'h0000;
            next_st.acc_ir = 16'h0000;
            next_st.pulses_left = 8'h00;
            next_st.pulse_cyc = 10'h000;
            next_st.run = 1'b0;
            unique case (next_st.state)
                lps_pkg::SEQ_PROX:
                begin
                    next_st.run = st.enable[lps_pkg::BIT_PROX_EN];
                    next_st.tmr_steps = to_steps(st.prox_conversion_time);
                    next_st.pulses_left = st.enable[lps_pkg::BIT_PROX_EN] ? st.pulses : 8'h00;
                end
                lps_pkg::SEQ_WAIT:
                begin
                    next_st.run = st.enable[lps_pkg::BIT_WAIT_EN];
                    next_st.tmr_steps = to_steps(st.wait_time_setting);
                end
                lps_pkg::SEQ_LIGHT:
                begin
                    next_st.run = st.enable[lps_pkg::BIT_LIGHT_EN];
                    next_st.tmr_steps = to_steps(st.light_integration_time);
                end
                default:
                begin
                    next_st.run = 1'b0;
                end
            endcase
            next_st.tmr_start = next_st.run;
        end
        next_st.led = (next_st.state == lps_pkg::SEQ_PROX) && (next_st.pulses_left != 8'h00)
                      && (next_st.pulse_cyc < ON_CYC);

        // Bus slave: request taken, one cycle later waitrequest drops
        next_st.ack = (i_avs_read || i_avs_write) && !st.ack;
        next_st.waitreq = !next_st.ack;
        if (i_avs_read && !st.ack)
        begin
            next_st.rdata = 32'h0000_0000;
            unique case (i_avs_address[7:2])
                lps_pkg::IDX_ENABLE: next_st.rdata[7:0] = st.enable;
                lps_pkg::IDX_LIGHT_TIME: next_st.rdata[7:0] = st.light_integration_time;
                lps_pkg::IDX_PROX_TIME: next_st.rdata[7:0] = st.prox_conversion_time;
                lps_pkg::IDX_WAIT_TIME: next_st.rdata[7:0] = st.wait_time_setting;
                lps_pkg::IDX_PULSES: next_st.rdata[7:0] = st.pulses;
                lps_pkg::IDX_CONTROL: next_st.rdata[7:0] = st.control;
                lps_pkg::IDX_STATUS: next_st.rdata[7:0] = {5'h00, st.state};
                // Low byte read freezes the high byte of the same word
                lps_pkg::IDX_CLEAR_LO:
                begin
                    next_st.rdata[7:0] = st.clear_channel_count[7:0];
                    next_st.shadow = st.clear_channel_count[15:8];
                end
                lps_pkg::IDX_IR_LO:
                begin
                    next_st.rdata[7:0] = st.infrared_channel_count[7:0];
                    next_st.shadow = st.infrared_channel_count[15:8];
                end
                lps_pkg::IDX_PROX_LO:
                begin
                    next_st.rdata[7:0] = st.prox_count[7:0];
                    next_st.shadow = st.prox_count[15:8];
                end
                lps_pkg::IDX_CLEAR_HI, lps_pkg::IDX_IR_HI, lps_pkg::IDX_PROX_HI:
                    next_st.rdata[7:0] = st.shadow;
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end
        if (i_avs_write && st.ack && i_avs_byteenable[0])
        begin
            unique case (i_avs_address[7:2])
                lps_pkg::IDX_ENABLE: next_st.enable = i_avs_writedata[7:0];
                lps_pkg::IDX_LIGHT_TIME: next_st.light_integration_time = i_avs_writedata[7:0];
                lps_pkg::IDX_PROX_TIME: next_st.prox_conversion_time = i_avs_writedata[7:0];
                lps_pkg::IDX_WAIT_TIME: next_st.wait_time_setting = i_avs_writedata[7:0];
                lps_pkg::IDX_PULSES: next_st.pulses = i_avs_writedata[7:0];
                lps_pkg::IDX_CONTROL: next_st.control = i_avs_writedata[7:0];
                default: next_st.control = st.control;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st <= '0;
            st.state <= lps_pkg::SEQ_SLEEP;
            st.enable <= lps_pkg::RST_ENABLE;
            st.light_integration_time <= lps_pkg::RST_TIME;
            st.prox_conversion_time <= lps_pkg::RST_TIME;
            st.wait_time_setting <= lps_pkg::RST_TIME;
            st.pulses <= lps_pkg::RST_PULSES;
            st.control <= lps_pkg::RST_CONTROL;
            st.waitreq <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign step.start = st.tmr_start;
    assign step.steps = st.tmr_steps;

    lps_step_timer #(.P_STEP_CYCLES(P_STEP_CYCLES)) u_timer (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .step(step)
    );

    assign o_avs_readdata = st.rdata;
    assign o_avs_waitrequest = st.waitreq;
    assign o_led_sink_output = st.led;
    // Drive code maps to sink current in the analog LED driver
    assign o_led_drive_level = st.control[lps_pkg::DRIVE_LSB +: 2];

    a_sleep_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        st.state == lps_pkg::SEQ_SLEEP |-> !st.led && !st.tmr_start)
        else $error("activity in sleep");
    a_power_wakes: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        st.state == lps_pkg::SEQ_SLEEP && st.enable[0] |=> st.state == lps_pkg::SEQ_START)
        else $error("power-on did not wake");
    a_prox_order: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        st.state == lps_pkg::SEQ_PROX ##1 st.state != lps_pkg::SEQ_PROX
        |-> st.state == lps_pkg::SEQ_WAIT || st.state == lps_pkg::SEQ_SLEEP)
        else $error("prox not followed by wait");
    a_skip_wait: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        st.state == lps_pkg::SEQ_WAIT && !st.run |=> st.state != lps_pkg::SEQ_WAIT)
        else $error("disabled wait not skipped");
    a_led_enabled: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        st.led |-> st.state == lps_pkg::SEQ_PROX && st.run)
        else $error("led outside enabled prox");
    a_zero_pulses: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        $rose(st.state == lps_pkg::SEQ_PROX) && st.pulses == 8'h00 |-> !st.led [*8])
        else $error("led lit with zero pulses");
    a_led_on_time: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        $fell(st.led) && st.state == lps_pkg::SEQ_PROX |-> $past(st.pulse_cyc) == ON_CYC - 10'h001)
        else $error("led on time wrong");
    a_data_update: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        $changed(st.clear_channel_count) |-> $past(st.state) == lps_pkg::SEQ_LIGHT && $past(st.tdone))
        else $error("data changed mid conversion");
    a_bus_answer: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("bus answer not one cycle");
endmodule : lps_sequencer

// file: testbench/lps_conv_model.sv
/*
 * Far-side partner: the two photodiode converters and the external IR LED.
 * Assumes one clock shared with the sequencer; counts are one-cycle pulses.
 */
`timescale 1ns/100ps
module lps_conv_model (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_clear_on,
    input wire logic i_ir_on,
    input wire logic i_led,
    input wire logic i_stat_clr,
    output logic o_clear_pulse,
    output logic o_ir_pulse,
    output logic [15:0] o_led_count,
    output logic [15:0] o_led_width,
    output logic [15:0] o_led_period
);
    logic phase;
    logic led_q;
    logic [15:0] on_cnt;
    logic [15:0] gap_cnt;
    // One count every other cycle: twice the full-scale rate, so every conversion saturates
    assign o_clear_pulse = phase & i_clear_on;
    assign o_ir_pulse = phase & i_ir_on;
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            phase <= 1'b0;
            led_q <= 1'b0;
            on_cnt <= 16'h0000;
            gap_cnt <= 16'h0000;
            o_led_count <= 16'h0000;
            o_led_width <= 16'h0000;
            o_led_period <= 16'h0000;
        end
        else
        begin
            phase <= ~phase;
            led_q <= i_led;
            gap_cnt <= gap_cnt + 16'h0001;
            on_cnt <= on_cnt + {15'h0000, i_led};
            if (i_led && !led_q)
            begin
                o_led_count <= i_stat_clr ? 16'h0001 : o_led_count + 16'h0001;
                o_led_period <= gap_cnt;
                gap_cnt <= 16'h0001;
                on_cnt <= 16'h0001;
            end
            else if (i_stat_clr)
                o_led_count <= 16'h0000;
            if (!i_led && led_q)
                o_led_width <= on_cnt;
        end
    end
endmodule : lps_conv_model

// file: testbench/tb_top.sv
/*
 * Self-checking bench of the measurement sequencer: Avalon-MM master tasks,
 * converter and LED partner, read expectations queued for a monitor.
 * Assumes a 40 MHz clock; bus tasks wait on waitrequest, only the watchdog ends a hang.
 */
`timescale 1ns/100ps
module tb_top;
    // Short step keeps the run small while counts still saturate
    localparam int STEP = 4096;
    typedef struct {logic chk; logic [7:0] exp; string name;} lps_note_s;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic clear_pulse;
    logic ir_pulse;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic led;
    logic [1:0] drive;
    logic clear_on = 1'b1;
    logic ir_on = 1'b1;
    logic stat_clr = 1'b0;
    logic [15:0] led_count;
    logic [15:0] led_width;
    logic [15:0] led_period;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    lps_note_s notes[$];
    logic [5:0] ridx [12] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h0E, 6'h0F, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h3F};
    logic [7:0] rexp [12] = '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    lps_sequencer #(.P_STEP_CYCLES(STEP)) lps_sequencer_inst (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
        .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
        .i_avs_byteenable(avs_byteenable), .i_avs_writedata(avs_writedata), .i_clear_pulse(clear_pulse),
        .i_ir_pulse(ir_pulse), .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
        .o_led_sink_output(led), .o_led_drive_level(drive));
    lps_conv_model lps_conv_model_inst (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_clear_on(clear_on),
        .i_ir_on(ir_on), .i_led(led), .i_stat_clr(stat_clr), .o_clear_pulse(clear_pulse),
        .o_ir_pulse(ir_pulse), .o_led_count(led_count), .o_led_width(led_width), .o_led_period(led_period));

    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;

    task automatic compare(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
        end
    endtask : compare

    // Monitor: each answered read takes the oldest note
    always @(posedge sys_clk)
    begin : take_note
        lps_note_s n;
        if (rst_n === 1'b1 && avs_read === 1'b1 && avs_waitrequest === 1'b0 && notes.size() > 0)
        begin
            n = notes.pop_front();
            if (n.chk)
                compare(n.name, {24'h000000, n.exp}, avs_readdata);
        end
    end

    task automatic bus_wr(input logic [5:0] idx, input logic [7:0] d, input logic [3:0] be);
        @(posedge sys_clk);
        avs_address <= {idx, 2'h0};
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= be;
        avs_write <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [5:0] idx, input logic chk, input logic [7:0] exp, input string nm,
                          output logic [7:0] d);
        notes.push_back('{chk, exp, nm});
        @(posedge sys_clk);
        avs_address <= {idx, 2'h0};
        avs_read <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata[7:0];
        avs_read <= 1'b0;
    endtask : bus_rd

    task automatic chk_rd(input logic [5:0] idx, input logic [7:0] exp, input string nm);
        logic [7:0] d;
        bus_rd(idx, 1'b1, exp, nm, d);
    endtask : chk_rd

    // Polls status until it equals s (eq high) or differs from s (eq low)
    task automatic wait_state(input logic [2:0] s, input logic eq, output logic [2:0] st);
        logic [7:0] d;
        do bus_rd(lps_pkg::IDX_STATUS, 1'b0, 8'h00, "status", d); while ((d[2:0] === s) !== eq);
        st = d[2:0];
    endtask : wait_state

    task automatic clr_stats();
        stat_clr <= 1'b1;
        @(posedge sys_clk);
        stat_clr <= 1'b0;
    endtask : clr_stats

    function automatic logic [31:0] win(input int d);
        return {31'h0, d >= STEP - 8 && d <= STEP + 8};
    endfunction : win

    function automatic logic [31:0] next_ok(input logic [2:0] a, input logic [2:0] b);
        return {31'h0, (a == 3'h0 && (b == 3'h1 || b == 3'h2)) || (a == 3'h1 && b == 3'h2) ||
            (a == 3'h2 && b == 3'h3) || (a == 3'h3 && b == 3'h4) || (a == 3'h4 && (b == 3'h1 || b == 3'h2))};
    endfunction : next_ok

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    initial
    begin
        repeat (95000) @(posedge sys_clk);
        fail_count++;
        $display("watchdog expired");
        print_verdict();
    end

    initial
    begin : main
        logic [31:0] r;
        logic [2:0] st;
        logic [2:0] prev;
        int t;
        r = $urandom(32'h9416);
        repeat (20) @(posedge sys_clk);
        compare("led in reset", 32'h0, {31'h0, led});
        rst_n <= 1'b1;
        repeat (100) @(posedge sys_clk);
        for (int i = 0; i < 12; i++)
            chk_rd(ridx[i], rexp[i], "reset value");
        $display("test reset done");
        r = $urandom;
        bus_wr(lps_pkg::IDX_PULSES, r[7:0], 4'h1);
        bus_wr(lps_pkg::IDX_PULSES, ~r[7:0], 4'h0);
        chk_rd(lps_pkg::IDX_PULSES, r[7:0], "pulses");
        bus_wr(lps_pkg::IDX_STATUS, 8'hFF, 4'h1);
        chk_rd(lps_pkg::IDX_STATUS, 8'h00, "status");
        for (int c = 0; c < 4; c++)
        begin
            bus_wr(lps_pkg::IDX_CONTROL, {c[1:0], r[13:8]}, 4'h1);
            repeat (2) @(posedge sys_clk);
            compare("drive level", c, {30'h0, drive});
        end
        $display("test registers done");
        ir_on <= 1'b0;
        bus_wr(lps_pkg::IDX_LIGHT_TIME, 8'hFE, 4'h1);
        clr_stats();
        bus_wr(lps_pkg::IDX_ENABLE, 8'h0B, 4'h1);
        wait_state(3'h4, 1'b1, st);
        wait_state(3'h4, 1'b0, st);
        t = cyc;
        wait_state(3'h3, 1'b1, st);
        compare("pass through", 32'h1, {31'h0, cyc - t <= 8});
        chk_rd(lps_pkg::IDX_CLEAR_LO, 8'h00, "clear lo");
        chk_rd(lps_pkg::IDX_CLEAR_HI, 8'h08, "clear hi");
        chk_rd(lps_pkg::IDX_IR_LO, 8'h00, "ir lo");
        chk_rd(lps_pkg::IDX_IR_HI, 8'h00, "ir hi");
        compare("led off", 32'h0, {16'h0, led_count});
        $display("test light done");
        bus_wr(lps_pkg::IDX_PULSES, 8'h03, 4'h1);
        clr_stats();
        bus_wr(lps_pkg::IDX_ENABLE, 8'h0D, 4'h1);
        wait_state(3'h2, 1'b1, st);
        wait_state(3'h2, 1'b0, st);
        compare("led pulses", 32'h3, {16'h0, led_count});
        compare("led width", lps_pkg::LED_ON_CYC, {16'h0, led_width});
        compare("led period", lps_pkg::PULSE_PER_CYC, {16'h0, led_period});
        bus_wr(lps_pkg::IDX_PULSES, 8'h00, 4'h1);
        clr_stats();
        wait_state(3'h2, 1'b1, st);
        t = cyc;
        wait_state(3'h2, 1'b0, st);
        compare("prox time", 32'h1, win(cyc - t));
        compare("no pulses", 32'h0, {16'h0, led_count});
        $display("test proximity done");
        ir_on <= 1'b1;
        bus_wr(lps_pkg::IDX_ENABLE, 8'h0B, 4'h1);
        wait_state(3'h4, 1'b1, st);
        bus_wr(lps_pkg::IDX_ENABLE, 8'h0A, 4'h1);
        wait_state(3'h4, 1'b0, st);
        chk_rd(lps_pkg::IDX_STATUS, 8'h00, "sleep");
        chk_rd(lps_pkg::IDX_CLEAR_LO, 8'h00, "clear lo");
        chk_rd(lps_pkg::IDX_CLEAR_HI, 8'h08, "clear hi");
        chk_rd(lps_pkg::IDX_IR_LO, 8'h00, "ir lo");
        chk_rd(lps_pkg::IDX_IR_HI, 8'h08, "ir hi");
        $display("test power off done");
        bus_wr(lps_pkg::IDX_LIGHT_TIME, 8'hFF, 4'h1);
        bus_wr(lps_pkg::IDX_ENABLE, 8'h0F, 4'h1);
        prev = 3'h0;
        t = cyc;
        repeat (4)
        begin
            wait_state(prev, 1'b0, st);
            compare("state order", 32'h1, next_ok(prev, st));
            if (st === 3'h4)
                compare("wait time", 32'h1, win(cyc - t));
            t = cyc;
            prev = st;
        end
        bus_wr(lps_pkg::IDX_ENABLE, 8'h07, 4'h1);
        wait_state(3'h2, 1'b1, st);
        wait_state(3'h2, 1'b0, st);
        t = cyc;
        wait_state(3'h4, 1'b1, st);
        compare("wait skipped", 32'h1, {31'h0, cyc - t <= 8});
        $display("test order done");
        print_verdict();
    end
endmodule : tb_top
